/* fifo_ctl_pkg.sv */
// shared constants and types for the serial channel queue control block
package fifo_ctl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 8;
  localparam int COUNT_W = 5;
  localparam int EVT_W   = 3;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK   = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_RX_LEVEL   = 3'h7;

  // ----------------------------------------------------------------
  // fifo_control and interrupt enable field positions
  // ----------------------------------------------------------------
  localparam int FIFO_ENABLE_BIT        = 0;
  localparam int RX_FIFO_CLEAR_BIT      = 1;
  localparam int TX_FIFO_CLEAR_BIT      = 2;
  localparam int DMA_MODE_SELECT_BIT    = 3;
  localparam int TRIGGER_LEVEL_LOW_BIT  = 6;
  localparam int TRIGGER_LEVEL_HIGH_BIT = 7;
  localparam int RX_DATA_INT_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // reset values, levels and counts
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0]  FIFO_CTRL_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] TRIG_LEVEL_0    = 5'h01;
  localparam logic [COUNT_W-1:0] TRIG_LEVEL_1    = 5'h04;
  localparam logic [COUNT_W-1:0] TRIG_LEVEL_2    = 5'h08;
  localparam logic [COUNT_W-1:0] TRIG_LEVEL_3    = 5'h0e;
  localparam logic [COUNT_W-1:0] QUEUE_DEPTH     = 5'h10;
  localparam logic [COUNT_W-1:0] COUNT_EMPTY     = 5'h00;
  localparam logic [2:0]         CHAR_TIMEOUT    = 3'h4;

  // ----------------------------------------------------------------
  // interrupt_ident codes and event bits
  // ----------------------------------------------------------------
  localparam logic [3:0] IDENT_NONE    = 4'h1;
  localparam logic [3:0] IDENT_RX_DATA = 4'h4;
  localparam logic [3:0] IDENT_TIMEOUT = 4'hc;
  localparam logic [1:0] IDENT_FIFO_ON = 2'h3;
  localparam int EVT_RX_TRIGGER = 0;
  localparam int EVT_TIMEOUT    = 1;
  localparam int EVT_TX_EMPTY   = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] trigger;
    logic       dma_mode;
    logic       enable;
  } fifo_ctrl_t;

  typedef struct packed {
    logic [COUNT_W-1:0] rx_count;
    logic [COUNT_W-1:0] tx_count;
    logic               rx_push;
    logic               rx_pop;
    logic               char_tick;
  } queue_state_t;

endpackage

/* fifo_queue_ctrl.sv */
// queue control register, dma request pins and receive interrupts
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module fifo_queue_ctrl (
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic [fifo_ctl_pkg::ADDR_W-1:0]    addr,
  input  wire logic [fifo_ctl_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                               wr_en,
  input  wire logic                               rd_en,
  output logic      [fifo_ctl_pkg::DATA_W-1:0]    rd_data,
  input  wire fifo_ctl_pkg::queue_state_t         queue,
  output logic                                    fifo_enable,
  output logic                                    rx_fifo_clear,
  output logic                                    tx_fifo_clear,
  output logic                                    rx_dma_request_n,
  output logic                                    tx_dma_request_n,
  output logic                                    irq
);

  fifo_ctl_pkg::fifo_ctrl_t            ctrl_ff;
  fifo_ctl_pkg::fifo_ctrl_t            nxt_ctrl;
  logic                                ier_ff;
  logic                                nxt_ier;
  logic                                rx_clr_ff;
  logic                                nxt_rx_clr;
  logic                                tx_clr_ff;
  logic                                nxt_tx_clr;
  logic [fifo_ctl_pkg::EVT_W-1:0]      status_ff;
  logic [fifo_ctl_pkg::EVT_W-1:0]      nxt_status;
  logic [fifo_ctl_pkg::EVT_W-1:0]      mask_ff;
  logic [fifo_ctl_pkg::EVT_W-1:0]      nxt_mask;
  logic [fifo_ctl_pkg::EVT_W-1:0]      cause_ff;
  logic [fifo_ctl_pkg::EVT_W-1:0]      cause;
  logic                                irq_ff;
  logic                                nxt_irq;
  logic [fifo_ctl_pkg::DATA_W-1:0]     rd_data_ff;
  logic [fifo_ctl_pkg::DATA_W-1:0]     nxt_rd_data;
  logic                                rx_hold_ff;
  logic                                nxt_rx_hold;
  logic                                tx_hold_ff;
  logic                                nxt_tx_hold;
  logic                                rx_req_n_ff;
  logic                                nxt_rx_req_n;
  logic                                tx_req_n_ff;
  logic                                nxt_tx_req_n;
  logic                                ctrl_wr;
  logic                                mode1;
  logic                                timeout;
  logic                                rx_avail;
  logic [fifo_ctl_pkg::COUNT_W-1:0]    trig_level;
  logic [3:0]                          ident;

  // ----------------------------------------------------------------
  // decode and derived conditions
  // ----------------------------------------------------------------
  assign ctrl_wr = wr_en && addr == fifo_ctl_pkg::ADDR_FIFO_CTRL;
  assign mode1   = ctrl_ff.enable && ctrl_ff.dma_mode;

  // trigger field to byte count
  always_comb begin
    unique case (ctrl_ff.trigger)
      2'h0: trig_level = fifo_ctl_pkg::TRIG_LEVEL_0;
      2'h1: trig_level = fifo_ctl_pkg::TRIG_LEVEL_1;
      2'h2: trig_level = fifo_ctl_pkg::TRIG_LEVEL_2;
      2'h3: trig_level = fifo_ctl_pkg::TRIG_LEVEL_3;
    endcase
  end

  // character mode treats a single held byte as available
  assign rx_avail = ctrl_ff.enable ? (queue.rx_count >= trig_level)
                                   : (queue.rx_count != '0);

  rx_char_timeout u_timeout (
    .core_clk  (core_clk),
    .rst       (rst),
    .rx_count  (queue.rx_count),
    .activity  (queue.rx_push || queue.rx_pop),
    .char_tick (queue.char_tick),
    .timeout   (timeout)
  );

  // identification: timeout outranks trigger, both gated by ier_ff, timeout also by enable bit
  always_comb begin
    ident = fifo_ctl_pkg::IDENT_NONE;
    if (ier_ff && ctrl_ff.enable && timeout) begin
      ident = fifo_ctl_pkg::IDENT_TIMEOUT;
    end else if (ier_ff && rx_avail) begin
      ident = fifo_ctl_pkg::IDENT_RX_DATA;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // flush pulses last one cycle; the queues clear their own counters
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_ier    = ier_ff;
    nxt_rx_clr = 1'b0;
    nxt_tx_clr = 1'b0;
    if (ctrl_wr) begin
      nxt_ctrl.enable = wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT];
      // bits four and five are simply dropped
      if (wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT]) begin
        nxt_ctrl.dma_mode =
          wr_data[fifo_ctl_pkg::DMA_MODE_SELECT_BIT];
        nxt_ctrl.trigger  =
          {wr_data[fifo_ctl_pkg::TRIGGER_LEVEL_HIGH_BIT],
           wr_data[fifo_ctl_pkg::TRIGGER_LEVEL_LOW_BIT]};
      end
      nxt_rx_clr = (wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT] &&
                    wr_data[fifo_ctl_pkg::RX_FIFO_CLEAR_BIT]) ||
                   (wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT] !=
                    ctrl_ff.enable);
      nxt_tx_clr = (wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT] &&
                    wr_data[fifo_ctl_pkg::TX_FIFO_CLEAR_BIT]) ||
                   (wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT] !=
                    ctrl_ff.enable);
    end
    if (wr_en && addr == fifo_ctl_pkg::ADDR_INT_ENABLE) begin
      nxt_ier = wr_data[fifo_ctl_pkg::RX_DATA_INT_ENABLE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_ff   <= fifo_ctl_pkg::fifo_ctrl_t'(fifo_ctl_pkg::FIFO_CTRL_RESET);
      ier_ff    <= 1'b0;
      rx_clr_ff <= 1'b0;
      tx_clr_ff <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      ier_ff    <= nxt_ier;
      rx_clr_ff <= nxt_rx_clr;
      tx_clr_ff <= nxt_tx_clr;
    end
  end

  // ----------------------------------------------------------------
  // dma request pins
  // ----------------------------------------------------------------
  // mode 1 keeps hysteresis so the dma engine moves bursts
  always_comb begin
    nxt_rx_hold = rx_hold_ff;
    if (queue.rx_count == fifo_ctl_pkg::COUNT_EMPTY) begin
      nxt_rx_hold = 1'b0;
    end else if (queue.rx_count >= trig_level || timeout) begin
      nxt_rx_hold = 1'b1;
    end
    nxt_tx_hold = tx_hold_ff;
    if (queue.tx_count == fifo_ctl_pkg::COUNT_EMPTY) begin
      nxt_tx_hold = 1'b1;
    end else if (queue.tx_count == fifo_ctl_pkg::QUEUE_DEPTH) begin
      nxt_tx_hold = 1'b0;
    end
    if (mode1) begin
      nxt_rx_req_n = !nxt_rx_hold;
      nxt_tx_req_n = !nxt_tx_hold;
    end else begin
      nxt_rx_req_n = (queue.rx_count == fifo_ctl_pkg::COUNT_EMPTY);
      nxt_tx_req_n = (queue.tx_count != fifo_ctl_pkg::COUNT_EMPTY);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_hold_ff  <= 1'b0;
      tx_hold_ff  <= 1'b0;
      rx_req_n_ff <= 1'b1;
      tx_req_n_ff <= 1'b1;
    end else begin
      rx_hold_ff  <= nxt_rx_hold;
      tx_hold_ff  <= nxt_tx_hold;
      rx_req_n_ff <= nxt_rx_req_n;
      tx_req_n_ff <= nxt_tx_req_n;
    end
  end

  // ----------------------------------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------------------------------
  // rising edges only, so a standing condition does not refire
  assign cause[fifo_ctl_pkg::EVT_RX_TRIGGER] = rx_avail;
  assign cause[fifo_ctl_pkg::EVT_TIMEOUT]    = timeout;
  assign cause[fifo_ctl_pkg::EVT_TX_EMPTY]   =
    (queue.tx_count == fifo_ctl_pkg::COUNT_EMPTY);

  // set wins over a write-one clear in the same cycle
  always_comb begin
    nxt_status = status_ff;
    nxt_mask   = mask_ff;
    if (wr_en && addr == fifo_ctl_pkg::ADDR_EVT_STATUS) begin
      nxt_status = status_ff & ~wr_data[fifo_ctl_pkg::EVT_W-1:0];
    end
    if (wr_en && addr == fifo_ctl_pkg::ADDR_EVT_MASK) begin
      nxt_mask = wr_data[fifo_ctl_pkg::EVT_W-1:0];
    end
    nxt_status = nxt_status | (cause & ~cause_ff);
    nxt_irq    = |(nxt_status & nxt_mask);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_ff <= '0;
      mask_ff   <= '0;
      cause_ff  <= cause; // no false event from an idle empty queue
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      cause_ff  <= cause;
      irq_ff    <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // data stand one cycle only; unmapped addresses read zero
  always_comb begin
    nxt_rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        fifo_ctl_pkg::ADDR_FIFO_CTRL:
          nxt_rd_data = {(ctrl_ff.enable ? fifo_ctl_pkg::IDENT_FIFO_ON
                                         : 2'h0),
                         2'h0, ident};
        fifo_ctl_pkg::ADDR_INT_ENABLE:
          nxt_rd_data = {7'h00, ier_ff};
        fifo_ctl_pkg::ADDR_EVT_STATUS:
          nxt_rd_data = {5'h00, status_ff};
        fifo_ctl_pkg::ADDR_EVT_MASK:
          nxt_rd_data = {5'h00, mask_ff};
        fifo_ctl_pkg::ADDR_RX_LEVEL:
          nxt_rd_data = {3'h0, queue.rx_count};
        default:
          nxt_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data          = rd_data_ff;
  assign fifo_enable      = ctrl_ff.enable;
  assign rx_fifo_clear    = rx_clr_ff;
  assign tx_fifo_clear    = tx_clr_ff;
  assign rx_dma_request_n = rx_req_n_ff;
  assign tx_dma_request_n = tx_req_n_ff;
  assign irq              = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_enabled_write;
    ctrl_wr && wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT];
  endsequence

  sequence s_disabled_write;
    ctrl_wr && !wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT];
  endsequence

  chk_rx_clear_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    s_enabled_write and wr_data[fifo_ctl_pkg::RX_FIFO_CLEAR_BIT]
    |=> rx_fifo_clear ##1 (!rx_fifo_clear || $past(ctrl_wr)))
    else $error("receive clear pulse wrong");

  chk_tx_clear_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    s_enabled_write and wr_data[fifo_ctl_pkg::TX_FIFO_CLEAR_BIT]
    |=> tx_fifo_clear)
    else $error("transmit clear pulse missing");

  chk_mode_change_flush: assert property (
    @(posedge core_clk) disable iff (rst)
    ctrl_wr && wr_data[fifo_ctl_pkg::FIFO_ENABLE_BIT] != fifo_enable
    |=> rx_fifo_clear && tx_fifo_clear)
    else $error("mode change did not flush");

  chk_fields_gated: assert property (
    @(posedge core_clk) disable iff (rst)
    s_disabled_write |=> !fifo_enable && $stable(ctrl_ff.trigger)
                         && $stable(ctrl_ff.dma_mode))
    else $error("fields changed without enable");

  chk_rx_mode0_req: assert property (
    @(posedge core_clk) disable iff (rst)
    !mode1 |=> (rx_dma_request_n ==
                ($past(queue.rx_count) == fifo_ctl_pkg::COUNT_EMPTY)))
    else $error("mode 0 receive request wrong");

  chk_rx_mode1_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    mode1 && !rx_dma_request_n
    && queue.rx_count != fifo_ctl_pkg::COUNT_EMPTY
    |=> !rx_dma_request_n)
    else $error("mode 1 receive request released early");

  chk_tx_mode0_req: assert property (
    @(posedge core_clk) disable iff (rst)
    !mode1 && queue.tx_count == fifo_ctl_pkg::COUNT_EMPTY
    |=> !tx_dma_request_n)
    else $error("mode 0 transmit request missing");

  chk_tx_mode1_full: assert property (
    @(posedge core_clk) disable iff (rst)
    mode1 && queue.tx_count == fifo_ctl_pkg::QUEUE_DEPTH
    |=> tx_dma_request_n)
    else $error("mode 1 transmit request not released");

  chk_ident_top_bits: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_en && addr == fifo_ctl_pkg::ADDR_FIFO_CTRL && fifo_enable
    |=> rd_data[7:6] == fifo_ctl_pkg::IDENT_FIFO_ON)
    else $error("ident top bits not set");

  chk_trigger_ident: assert property (
    @(posedge core_clk) disable iff (rst)
    rd_en && addr == fifo_ctl_pkg::ADDR_FIFO_CTRL && ier_ff
    && fifo_enable && !timeout && queue.rx_count >= trig_level
    |=> rd_data[3:0] == fifo_ctl_pkg::IDENT_RX_DATA)
    else $error("trigger level not identified");

endmodule

/* queue_side_model.sv */
// behavioural occupancy model of the two queues behind the control block
`timescale 1ns/1ps
module queue_side_model (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic [4:0]            cmd,
  input  wire logic                  rx_fifo_clear,
  input  wire logic                  tx_fifo_clear,
  output fifo_ctl_pkg::queue_state_t queue
);
  // ----------------------------------------------------------------
  // occupancy counters
  // ----------------------------------------------------------------
  logic [4:0] rx_cnt_ff;
  logic [4:0] tx_cnt_ff;
  logic [2:0] pulse_ff;

  // counts saturate at sixteen, so a push into a full queue is lost
  always_ff @(posedge core_clk) begin
    if (rst || rx_fifo_clear) begin
      rx_cnt_ff <= 5'h00;
    end else if (cmd[0] && rx_cnt_ff != 5'h10) begin
      rx_cnt_ff <= rx_cnt_ff + 5'h01;
    end else if (cmd[1] && rx_cnt_ff != 5'h00) begin
      rx_cnt_ff <= rx_cnt_ff - 5'h01;
    end
    if (rst || tx_fifo_clear) begin
      tx_cnt_ff <= 5'h00;
    end else if (cmd[2] && tx_cnt_ff != 5'h10) begin
      tx_cnt_ff <= tx_cnt_ff + 5'h01;
    end else if (cmd[3] && tx_cnt_ff != 5'h00) begin
      tx_cnt_ff <= tx_cnt_ff - 5'h01;
    end
    pulse_ff <= rst ? 3'h0 : {cmd[0], cmd[1], cmd[4]};
  end

  // push, pop and tick pulses line up with the count change
  assign queue = {rx_cnt_ff, tx_cnt_ff, pulse_ff};
endmodule

/* rx_char_timeout.sv */
// character timeout watch on the receive queue
`timescale 1ns/1ps
module rx_char_timeout (
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  input  wire logic [fifo_ctl_pkg::COUNT_W-1:0]   rx_count,
  input  wire logic                               activity,
  input  wire logic                               char_tick,
  output logic                                    timeout
);

  logic [2:0] idle_ff;
  logic [2:0] nxt_idle;

  // ----------------------------------------------------------------
  // idle character counter
  // ----------------------------------------------------------------
  // restarts on any push or pop, saturates at the limit
  always_comb begin
    nxt_idle = idle_ff;
    if (activity || rx_count == fifo_ctl_pkg::COUNT_EMPTY) begin
      nxt_idle = '0;
    end else if (char_tick && idle_ff != fifo_ctl_pkg::CHAR_TIMEOUT) begin
      nxt_idle = idle_ff + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      idle_ff <= '0;
    end else begin
      idle_ff <= nxt_idle;
    end
  end

  assign timeout = (idle_ff == fifo_ctl_pkg::CHAR_TIMEOUT);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_timeout_needs_data: assert property (
    @(posedge core_clk) disable iff (rst)
    (rx_count == fifo_ctl_pkg::COUNT_EMPTY || activity) |=> !timeout)
    else $error("timeout flagged without idle data");

endmodule

/* tb_uart_fifo_control_dma_ready.sv */
// self-checking bench for the queue control and dma request block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", what, (exp), (got)); \
  end \
end
module tb_uart_fifo_control_dma_ready;
  logic                       core_clk;
  logic                       rst;
  logic [2:0]                 addr;
  logic [7:0]                 wr_data;
  logic                       wr_en;
  logic                       rd_en;
  logic [7:0]                 rd_data;
  fifo_ctl_pkg::queue_state_t queue;
  logic                       fifo_enable;
  logic                       rx_fifo_clear;
  logic                       tx_fifo_clear;
  logic                       rx_dma_request_n;
  logic                       tx_dma_request_n;
  logic                       irq;
  logic [4:0]                 cmd;
  logic [7:0]                 v;
  int                         mismatches;
  int                         checks;
  int                         lv[4] = '{1, 4, 8, 14};

  fifo_queue_ctrl fifo_queue_ctrl_i (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .queue(queue),
    .fifo_enable(fifo_enable), .rx_fifo_clear(rx_fifo_clear),
    .tx_fifo_clear(tx_fifo_clear), .rx_dma_request_n(rx_dma_request_n),
    .tx_dma_request_n(tx_dma_request_n), .irq(irq));

  queue_side_model queue_side_model_i (
    .core_clk(core_clk), .rst(rst), .cmd(cmd),
    .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear),
    .queue(queue));

  // ----------------------------------------------------------------
  // clock, bus and queue stimulus tasks
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // one-cycle write; returns just after the taking edge has landed
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // n single-cycle pulses on one queue command, then let pins settle
  task automatic move(input int idx, input int n);
    repeat (n) begin
      @(posedge core_clk);
      cmd[idx] <= 1'b1;
      @(posedge core_clk);
      cmd[idx] <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic mode0_disabled;
    `CHK("enable", 1'b0, fifo_enable)
    `CHK("tx_n empty", 1'b0, tx_dma_request_n)
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h4a);
    `CHK("no enable", 1'b0, fifo_enable)
    `CHK("no rx clr", 1'b0, rx_fifo_clear)
    move(2, 1);
    `CHK("tx_n loaded", 1'b1, tx_dma_request_n)
    move(3, 1);
    `CHK("tx_n drained", 1'b0, tx_dma_request_n)
    move(0, 1);
    `CHK("rx_n held", 1'b0, rx_dma_request_n)
    move(1, 1);
    `CHK("rx_n none", 1'b1, rx_dma_request_n)
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("ident off", 8'h01, v)
  endtask

  task automatic enable_and_clear;
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h01);
    `CHK("enable on", 1'b1, fifo_enable)
    `CHK("rx flush", 1'b1, rx_fifo_clear)
    `CHK("tx flush", 1'b1, tx_fifo_clear)
    @(posedge core_clk);
    #1;
    `CHK("rx self clr", 1'b0, rx_fifo_clear)
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h01);
    `CHK("no reflush", 1'b0, tx_fifo_clear)
    move(0, 2);
    move(2, 1);
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h03);
    `CHK("rx clr", 1'b1, rx_fifo_clear)
    `CHK("tx kept", 1'b0, tx_fifo_clear)
    move(0, 0);
    `CHK("rx_n emptied", 1'b1, rx_dma_request_n)
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h05);
    `CHK("tx clr", 1'b1, tx_fifo_clear)
    `CHK("rx kept", 1'b0, rx_fifo_clear)
    move(2, 0);
    `CHK("tx_n emptied", 1'b0, tx_dma_request_n)
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("ident on", 8'hc1, v)
  endtask

  // every trigger code in mode 1, reserved bits set on each write
  task automatic rx_mode1_levels;
    for (int c = 0; c < 4; c++) begin
      wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, {c[1:0], 6'h3f});
      move(0, lv[c] - 1);
      `CHK("rx_n below", 1'b1, rx_dma_request_n)
      move(0, 1);
      `CHK("rx_n trig", 1'b0, rx_dma_request_n)
      move(1, lv[c] - 1);
      `CHK("rx_n hold", 1'b0, rx_dma_request_n)
      move(1, 1);
      `CHK("rx_n empty", 1'b1, rx_dma_request_n)
    end
  endtask

  task automatic tx_mode1_fill;
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h09);
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("not readback", 8'hc1, v)
    move(2, 15);
    `CHK("tx_n 15", 1'b0, tx_dma_request_n)
    move(2, 1);
    `CHK("tx_n full", 1'b1, tx_dma_request_n)
    move(3, 15);
    `CHK("tx_n 1 left", 1'b1, tx_dma_request_n)
    move(3, 1);
    `CHK("tx_n again", 1'b0, tx_dma_request_n)
  endtask

  task automatic data_interrupt;
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h01);
    wr(fifo_ctl_pkg::ADDR_INT_ENABLE, 8'h01);
    wr(fifo_ctl_pkg::ADDR_EVT_STATUS, 8'h07);
    wr(fifo_ctl_pkg::ADDR_EVT_MASK, 8'h01);
    `CHK("irq idle", 1'b0, irq)
    move(0, 1);
    `CHK("irq trig", 1'b1, irq)
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("ident data", {2'b11, 2'b00, fifo_ctl_pkg::IDENT_RX_DATA}, v)
    rd(fifo_ctl_pkg::ADDR_EVT_STATUS, v);
    `CHK("status bit", 1'b1, v[0])
    wr(fifo_ctl_pkg::ADDR_EVT_STATUS, 8'h01);
    @(posedge core_clk);
    #1;
    `CHK("irq w1c", 1'b0, irq)
    move(1, 1);
    wr(fifo_ctl_pkg::ADDR_EVT_MASK, 8'h00);
    move(0, 1);
    `CHK("irq masked", 1'b0, irq)
    wr(fifo_ctl_pkg::ADDR_INT_ENABLE, 8'h00);
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("ident gated", 8'hc1, v)
    wr(fifo_ctl_pkg::ADDR_INT_ENABLE, 8'h01);
  endtask

  // one character held below trigger 14, ticks only drive the timeout;
  // drain first so the request hysteresis starts from an empty queue
  task automatic char_timeout;
    move(1, 1);
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'hc9);
    move(0, 1);
    `CHK("rx_n low lvl", 1'b1, rx_dma_request_n)
    rd(fifo_ctl_pkg::ADDR_RX_LEVEL, v);
    `CHK("rx level", 8'h01, v)
    move(4, 3);
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("ident 3 ticks", 8'hc1, v)
    move(4, 1);
    rd(fifo_ctl_pkg::ADDR_FIFO_CTRL, v);
    `CHK("ident timeout", {2'b11, 2'b00, fifo_ctl_pkg::IDENT_TIMEOUT}, v)
    `CHK("rx_n timeout", 1'b0, rx_dma_request_n)
    move(1, 1);
    `CHK("rx_n drained", 1'b1, rx_dma_request_n)
    wr(fifo_ctl_pkg::ADDR_FIFO_CTRL, 8'h00);
    `CHK("disable flush", 1'b1, rx_fifo_clear)
    `CHK("enable off", 1'b0, fifo_enable)
    rd(3'h3, v);
    `CHK("unmapped", 8'h00, v)
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    checks     = 0;
    rst        = 1'b1;
    addr       = 3'h0;
    wr_data    = 8'h00;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    cmd        = 5'h00;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("irq reset", 1'b0, irq)
    `CHK("rx_n reset", 1'b1, rx_dma_request_n)
    mode0_disabled();
    enable_and_clear();
    rx_mode1_levels();
    tx_mode1_fill();
    data_interrupt();
    char_timeout();
    tally_and_finish();
  end

  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
